// ===== logic/usep_chain.sv
// usep_chain: echo processing chain with shot control and apb registers
// Function
// R01 - drive beamformer clock enable and a shot trigger pulse per transmit
// R02 - shift transmit/receive focus, line, apodisation, multibeam before shots
// R03 - reorder pixel-major samples into shot-major order
// R04 - remove dc, mix to baseband, then low-pass filter
// R05 - magnitude of complex baseband, then compress to 8-bit log value
// R06 - resample before magnitude, then line filter, edge enhance, frame filter after log
// R07 - b-mode data leaves through channel zero toward dma zero
// R08 - m-mode and doppler data leave through channel zero toward dma one
// R09 - beamformer divides its clock by two or more for transmit
// R10 - beamformer makes sample clocks and receive focus, sums, weights
// R11 - each subboard serves sixteen channels, up to sixteen subboards
// R12 - pulse inversion: two opposite shots per line, subtracted
// R13 - harmonic mode demodulates at twice the receive frequency
// R14 - focus composite blends near and far shots into one line
// R15 - doppler data travel as 16-bit words on channel zero
// R16 - compound and volume contrast modes run as plain b-mode
// R17 - external video and archive modes keep the chain idle
// R18 - a full output fifo drops data and flags overflow
`timescale 1ns/1ps
module usep_chain (
  // system
  input  wire logic                 clk,
  input  wire logic                 reset,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // sample link, on the link clock
  input  wire logic                 lclk,
  input  wire logic                 smp_valid,
  input  wire logic [15:0]          smp_data,
  output logic                      smp_ready,
  // beamformer control
  output logic                      bf_clk_en,
  output logic                      shot_trig,
  output logic                      cfg_sclk,
  output logic                      cfg_sdata,
  output logic                      cfg_load,
  // sdram fifo writer, channel zero
  input  wire logic                 fifo_full,
  output logic                      out_valid,
  output logic      [15:0]          out_data,
  output logic                      out_dma
);
  import usep_pkg::*;

  // decoding shared by several places
  function automatic logic proc_mode(input logic [2:0] m);
    proc_mode = (m != MODE_EXTVID) && (m != MODE_ARCHIVE) && (m != 3'h7);
  endfunction
  function automatic logic dma_of(input logic [2:0] m);
    dma_of = (m == MODE_M || m == MODE_D) ? DMA_MD : DMA_BMODE;
  endfunction
  function automatic logic [SMP_W-1:0] mag(input logic signed [SMP_W-1:0] v);
    mag = v[SMP_W-1] ? SMP_W'(-v) : v;
  endfunction
  function automatic logic signed [7:0] cosv(input logic [2:0] p);
    case (p)
      3'h0:    cosv = 8'h7f;
      3'h1:    cosv = 8'h5a;
      3'h2:    cosv = 8'h00;
      3'h3:    cosv = 8'ha6;
      3'h4:    cosv = 8'h81;
      3'h5:    cosv = 8'ha6;
      3'h6:    cosv = 8'h00;
      default: cosv = 8'h5a;
    endcase
  endfunction
  function automatic logic [7:0] lg8(input logic [MAG_W-1:0] m);
    logic [4:0]       p;
    logic [MAG_W-1:0] n;
    p = 5'h00;
    for (int k = 0; k < MAG_W; k++)
      if (m[k]) p = 5'(k);
    n = m << (MAG_W - 1 - int'(p));
    lg8 = {p, n[MAG_W-2 -: 3]};
  endfunction

  logic [31:0]      ctrl, shot_per, rxf, geom, beam, apod;
  logic             ovf, cfg_done;
  logic [15:0]      shot_cnt;
  usep_state_e      state;
  logic [2:0]       mode;
  logic             active, pinv, fcomp;
  logic [PIX_W-1:0] pix_last;
  logic [SHOT_W-1:0] beam_last;
  assign mode      = ctrl[CTRL_MODE +: MODE_W];
  assign active    = ctrl[CTRL_RUN] & proc_mode(mode); // see R17 see R16
  assign pinv      = ctrl[CTRL_PINV];
  assign fcomp     = ctrl[CTRL_FCOMP];
  assign pix_last  = geom[G_PIX +: PIX_W];
  assign beam_last = geom[G_BEAM +: SHOT_W];

  // apb answer: one cycle after setup, zero wait states
  logic        setup, wr_en, mapped;
  logic [31:0] rd_val;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  always_comb
  begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      A_CTRL:  rd_val = ctrl;
      A_SHOT:  rd_val = shot_per;
      A_RXF:   rd_val = rxf;
      A_GEOM:  rd_val = geom;
      A_BEAM:  rd_val = beam;
      A_APOD:  rd_val = apod;
      A_STAT:  rd_val = {shot_cnt, 12'h000, cfg_done, ovf, state};
      default: mapped = 1'b0;
    endcase
  end
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
    end

  // register writes at the completing access edge
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      ctrl     <= CTRL_RST;
      shot_per <= SHOT_RST;
      rxf      <= RXF_RST;
      geom     <= GEOM_RST;
      beam     <= BEAM_RST;
      apod     <= APOD_RST;
    end
    else if (wr_en)
      case (paddr)
        A_CTRL: ctrl     <= pwdata;
        A_SHOT: shot_per <= pwdata;
        A_RXF:  rxf      <= pwdata;
        A_GEOM: geom     <= pwdata;
        A_BEAM: beam     <= {pwdata[31:8], (pwdata[7:0] < TXDIV_MIN)
                            ? TXDIV_MIN : pwdata[7:0]}; // see R09
        A_APOD: apod     <= pwdata;
        default: ;
      endcase

  // link side: capture a sample, toggle request, wait for the ack
  logic        lreq, ack_l1, ack_l2, mack;
  logic [15:0] lhold;
  always_ff @(posedge lclk or posedge reset)
    if (reset)
    begin
      lreq      <= 1'b0;
      lhold     <= 16'h0000;
      smp_ready <= 1'b0;
    end
    else if (smp_valid && smp_ready)
    begin
      lhold     <= smp_data;
      lreq      <= ~lreq;
      smp_ready <= 1'b0;
    end
    else
      smp_ready <= (lreq == ack_l2);
  // ack toggle into the link domain
  always_ff @(posedge lclk or posedge reset)
    if (reset)
    begin
      ack_l1 <= 1'b0;
      ack_l2 <= 1'b0;
    end
    else
    begin
      ack_l1 <= mack;
      ack_l2 <= ack_l1;
    end

  // request toggle into the main domain; lhold is stable until acked
  logic req_m1, req_m2, take;
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      req_m1 <= 1'b0;
      req_m2 <= 1'b0;
    end
    else
    begin
      req_m1 <= lreq;
      req_m2 <= req_m1;
    end

  // de-interleave buffer: written pixel-major, read shot-major
  logic [SMP_W-1:0]  di_mem [0:(1 << (PIX_W + SHOT_W)) - 1];
  logic              di_wr;
  logic [PIX_W-1:0]  wp, rp;
  logic [SHOT_W-1:0] ws, rs;
  logic signed [SMP_W:0] pdiff;
  assign take  = (req_m2 != mack) & di_wr & active;
  assign pdiff = {di_mem[{rs, rp}][SMP_W-1], di_mem[{rs, rp}]}
               - {di_mem[{rs ^ 2'h1, rp}][SMP_W-1], di_mem[{rs ^ 2'h1, rp}]};
  always_ff @(posedge clk)
    if (take)
      di_mem[{ws, wp}] <= lhold;
  always_ff @(posedge clk or posedge reset)
    if (reset)
      mack <= 1'b0;
    else if (take)
      mack <= req_m2;
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      di_wr <= 1'b1;
      wp    <= '0;
      ws    <= '0;
      rp    <= '0;
      rs    <= '0;
    end
    else if (di_wr)
    begin
      if (take && ws == beam_last)
      begin
        ws <= '0;
        wp <= (wp == pix_last) ? '0 : wp + 1'b1;
        if (wp == pix_last)
          di_wr <= 1'b0; // see R03
      end
      else if (take)
        ws <= ws + 1'b1;
    end
    else
    begin
      rp <= (rp == pix_last) ? '0 : rp + 1'b1; // see R03
      if (rp == pix_last)
      begin
        rs    <= (rs == beam_last) ? '0 : rs + 1'b1;
        di_wr <= (rs == beam_last);
      end
    end

  // stage 1: buffer output, pulse-inversion subtraction on odd shots
  logic                     s1_v, s1_last;
  logic signed [SMP_W-1:0]  s1_x;
  logic [PIX_W-1:0]         s1_pix;
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      s1_v    <= 1'b0;
      s1_last <= 1'b0;
      s1_x    <= '0;
      s1_pix  <= '0;
    end
    else
    begin
      s1_v    <= ~di_wr & (~pinv | rs[0]); // see R12
      s1_last <= (rs == beam_last);
      s1_x    <= pinv ? pdiff[SMP_W:1] : di_mem[{rs, rp}]; // see R12
      s1_pix  <= rp;
    end

  // stages 2 to 4: dc cancel, mixer, low-pass and decimation
  logic signed [SMP_W-1:0]  dc, s2_y, s3_i, s3_q, li, lq;
  logic signed [23:0]       prod_i, prod_q;
  logic [7:0]               phase, ph_inc;
  logic [DEC_W-1:0]         dcnt;
  logic                     s2_v, s3_v, s4_v, s2_last, s3_last, s4_last;
  logic [PIX_W-1:0]         s2_pix, s3_pix, s4_pix;
  assign ph_inc = ctrl[CTRL_HARM] ? {rxf[6:0], 1'b0} : rxf[7:0]; // see R13
  assign prod_i = s2_y * cosv(phase[7:5]);
  assign prod_q = s2_y * cosv(phase[7:5] - 3'h2);
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      {s2_v, s3_v, s4_v, s2_last, s3_last, s4_last} <= '0;
      {dc, s2_y, s3_i, s3_q, li, lq} <= '0;
      {s2_pix, s3_pix, s4_pix} <= '0;
      phase <= 8'h00;
      dcnt  <= '0;
    end
    else
    begin
      s2_v <= s1_v;
      s3_v <= s2_v;
      s4_v <= s3_v && dcnt == '0; // see R06
      {s2_last, s3_last, s4_last} <= {s1_last, s2_last, s3_last};
      {s2_pix, s3_pix, s4_pix}    <= {s1_pix, s2_pix, s3_pix};
      if (s1_v)
      begin
        dc   <= dc + ((s1_x - dc) >>> DC_SHIFT); // see R04
        s2_y <= s1_x - dc; // see R04
      end
      if (s2_v)
      begin
        s3_i  <= prod_i[MIX_SHIFT +: SMP_W]; // see R04 see R05
        s3_q  <= prod_q[MIX_SHIFT +: SMP_W];
        phase <= phase + ph_inc;
      end
      if (s3_v)
      begin
        li   <= li + ((s3_i - li) >>> LPF_SHIFT); // see R04
        lq   <= lq + ((s3_q - lq) >>> LPF_SHIFT);
        dcnt <= (dcnt == geom[G_DEC +: DEC_W]) ? '0 : dcnt + 1'b1;
      end
    end

  // stages 5 to 7: magnitude, log, line filter and edge enhance
  logic [MAG_W-1:0] s5_m;
  logic [7:0]       s6_lg, s7_px, prev_lg, prev_lf;
  logic             s5_v, s6_v, s7_v, s5_last, s6_last, s7_last;
  logic [PIX_W-1:0] s5_pix, s6_pix, s7_pix;
  logic [7:0]       next_lf, next_ed;
  logic signed [9:0] edge_sum;
  always_comb
  begin
    next_lf  = 8'((({1'b0, s6_lg} + {1'b0, prev_lg}) >> 1));
    edge_sum = {2'b00, next_lf} + {2'b00, next_lf} - {2'b00, prev_lf};
    next_ed  = edge_sum[9] ? 8'h00 : (edge_sum[8] ? 8'hff : edge_sum[7:0]);
  end
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      {s5_v, s6_v, s7_v, s5_last, s6_last, s7_last} <= '0;
      {s5_pix, s6_pix, s7_pix} <= '0;
      s5_m <= '0;
      {s6_lg, s7_px, prev_lg, prev_lf} <= '0;
    end
    else
    begin
      {s5_v, s6_v, s7_v} <= {s4_v, s5_v, s6_v};
      {s5_last, s6_last, s7_last} <= {s4_last, s5_last, s6_last};
      {s5_pix, s6_pix, s7_pix}    <= {s4_pix, s5_pix, s6_pix};
      if (s4_v)
        s5_m <= {1'b0, mag(li)} + {1'b0, mag(lq)}; // see R05
      if (s5_v)
        s6_lg <= lg8(s5_m); // see R05
      if (s6_v)
      begin
        prev_lg <= s6_lg;
        prev_lf <= next_lf;
        s7_px   <= next_ed; // see R06
      end
    end

  // stage 8: frame filter and near/far focus blending
  logic [7:0]       frame_mem [0:(1 << PIX_W) - 1];
  logic [7:0]       near_mem  [0:(1 << PIX_W) - 1];
  logic [7:0]       next_fr, s8_px;
  logic             s8_v;
  logic [(1 << PIX_W) - 1:0] fr_seen;
  // a pixel not seen yet takes the new value, no stale memory leaks out
  assign next_fr = fr_seen[s7_pix]
                 ? 8'((({1'b0, s7_px} + {1'b0, frame_mem[s7_pix]}) >> 1))
                 : s7_px;
  always_ff @(posedge clk or posedge reset)
    if (reset)
      fr_seen <= '0;
    else if (s7_v)
      fr_seen[s7_pix] <= 1'b1; // see R06
  always_ff @(posedge clk)
    if (s7_v)
    begin
      frame_mem[s7_pix] <= next_fr; // see R06
      if (fcomp && !s7_last)
        near_mem[s7_pix] <= next_fr; // see R14
    end
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      s8_v  <= 1'b0;
      s8_px <= 8'h00;
    end
    else
    begin
      s8_v  <= s7_v & (~fcomp | s7_last); // see R14
      s8_px <= (fcomp && s7_pix < geom[G_SPLIT +: PIX_W])
             ? near_mem[s7_pix] : next_fr; // see R14
    end

  // fifo writer: doppler sends 16-bit magnitude, else log pixels
  logic        cand_v;
  logic [15:0] cand_d;
  assign cand_v = (mode == MODE_D) ? s5_v : s8_v; // see R15
  assign cand_d = (mode == MODE_D) ? s5_m[15:0] : {8'h00, s8_px};
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      out_valid <= 1'b0;
      out_data  <= 16'h0000;
      out_dma   <= DMA_BMODE;
    end
    else
    begin
      out_valid <= cand_v & ~fifo_full & active; // see R18
      out_data  <= cand_d;
      out_dma   <= dma_of(mode); // see R07 see R08
    end
  // overflow flag: set wins over the write-one clear
  always_ff @(posedge clk or posedge reset)
    if (reset)
      ovf <= 1'b0;
    else if (cand_v && fifo_full && active)
      ovf <= 1'b1; // see R18
    else if (wr_en && paddr == A_STAT && pwdata[S_OVF])
      ovf <= 1'b0;

  // shot sequencer: load beamformer config, then fire shots
  logic [55:0]      cfg_sh;
  logic [CNT_W-1:0] cfg_cnt;
  logic [31:0]      prf;
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      state    <= ST_IDLE;
      cfg_sh   <= '0;
      cfg_cnt  <= '0;
      cfg_sclk <= 1'b0;
      cfg_sdata <= 1'b0;
      cfg_load <= 1'b0;
      cfg_done <= 1'b0;
    end
    else
    begin
      cfg_load <= 1'b0;
      unique case (state)
        ST_IDLE:
          if (active)
          begin
            state     <= ST_LOAD;
            cfg_done  <= 1'b0;
            cfg_sdata <= beam[31];
            cfg_sh    <= {beam[30:0], apod[15:0], 6'h00, beam_last, 1'b0};
            cfg_cnt   <= 6'h01;
          end
        ST_LOAD:
          if (!active)
          begin
            state    <= ST_IDLE;
            cfg_sclk <= 1'b0;
          end
          else if (!cfg_sclk)
            cfg_sclk <= 1'b1;
          else if (cfg_cnt == CFG_BITS)
          begin
            cfg_sclk <= 1'b0;
            cfg_load <= 1'b1;
            cfg_done <= 1'b1; // see R02
            state    <= ST_FIRE;
          end
          else
          begin
            cfg_sclk  <= 1'b0;
            cfg_sdata <= cfg_sh[55];
            cfg_sh    <= {cfg_sh[54:0], 1'b0};
            cfg_cnt   <= cfg_cnt + 1'b1;
          end
        ST_FIRE:
          if (!active)
            state <= ST_IDLE; // see R17
      endcase
    end
  // trigger pacing and beamformer clock enable
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      prf       <= '0;
      shot_trig <= 1'b0;
      shot_cnt  <= '0;
      bf_clk_en <= 1'b0;
    end
    else
    begin
      bf_clk_en <= active && state != ST_IDLE; // see R01
      shot_trig <= 1'b0;
      if (state != ST_FIRE || !active)
        prf <= '0;
      else if (prf == shot_per)
      begin
        prf       <= '0;
        shot_trig <= 1'b1; // see R01
        shot_cnt  <= shot_cnt + 1'b1;
      end
      else
        prf <= prf + 1'b1;
    end

  // checks
  property p_trig_clk;
    @(posedge clk) disable iff (reset) shot_trig |-> bf_clk_en;
  endproperty
  a_trig_clk: assert property (p_trig_clk) // see R01
    else $error("shot trigger without beamformer clock");
  property p_cfg_first;
    @(posedge clk) disable iff (reset) shot_trig |-> cfg_done && !cfg_sclk;
  endproperty
  a_cfg_first: assert property (p_cfg_first) // see R02
    else $error("shot fired before configuration load");
  property p_order;
    @(posedge clk) disable iff (reset)
      (!di_wr && rp != pix_last) |=> !di_wr && rp == $past(rp) + 1'b1
                                     && rs == $past(rs);
  endproperty
  a_order: assert property (p_order) // see R03
    else $error("de-interleave left shot before its last pixel");
  property p_chain;
    @(posedge clk) disable iff (reset) s1_v |=> s2_v ##1 s3_v;
  endproperty
  a_chain: assert property (p_chain) // see R04
    else $error("dc cancel and mixer stages out of step");
  property p_log_top;
    @(posedge clk) disable iff (reset) (s5_v && s5_m[MAG_W-1]) |=> s6_lg[7];
  endproperty
  a_log_top: assert property (p_log_top) // see R05
    else $error("full-scale magnitude did not reach log top range");
  property p_dma;
    @(posedge clk) disable iff (reset)
      (out_valid && $stable(mode)) |-> out_dma == dma_of(mode);
  endproperty
  a_dma: assert property (p_dma) // see R07
    else $error("data steered to wrong dma controller");
  property p_pinv;
    @(posedge clk) disable iff (reset) (s1_v && pinv) |-> $past(rs[0]);
  endproperty
  a_pinv: assert property (p_pinv) // see R12
    else $error("pulse inversion emitted an unpaired shot");
  property p_idle;
    @(posedge clk) disable iff (reset) !active |=> state == ST_IDLE ##1 !shot_trig;
  endproperty
  a_idle: assert property (p_idle) // see R17
    else $error("chain kept firing in an idle mode");
  property p_full;
    @(posedge clk) disable iff (reset)
      (cand_v && fifo_full && active) |=> !out_valid && ovf;
  endproperty
  a_full: assert property (p_full) // see R18
    else $error("write to full fifo not refused and flagged");
endmodule

// ===== logic/usep_pkg.sv
// usep_pkg: shared constants and types of the ultrasound echo chain
package usep_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SHOT = 8'h04;
  localparam logic [7:0] A_RXF  = 8'h08;
  localparam logic [7:0] A_GEOM = 8'h0c;
  localparam logic [7:0] A_BEAM = 8'h10;
  localparam logic [7:0] A_APOD = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  // control register fields
  localparam int CTRL_MODE  = 0;
  localparam int MODE_W     = 3;
  localparam int CTRL_RUN   = 3;
  localparam int CTRL_HARM  = 4;
  localparam int CTRL_PINV  = 5;
  localparam int CTRL_FCOMP = 6;
  // operating mode codes
  localparam logic [2:0] MODE_B        = 3'h0;
  localparam logic [2:0] MODE_M        = 3'h1;
  localparam logic [2:0] MODE_D        = 3'h2;
  localparam logic [2:0] MODE_EXTVID   = 3'h3;
  localparam logic [2:0] MODE_ARCHIVE  = 3'h4;
  localparam logic [2:0] MODE_COMPOUND = 3'h5;
  localparam logic [2:0] MODE_VOLCON   = 3'h6;
  // geometry and status fields
  localparam int G_PIX   = 0;
  localparam int G_BEAM  = 8;
  localparam int G_DEC   = 12;
  localparam int G_SPLIT = 16;
  localparam int S_OVF   = 2;
  localparam int S_CFG   = 3;
  localparam int S_SHOTS = 16;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SHOT_RST = 32'h0000_00ff;
  localparam logic [31:0] RXF_RST  = 32'h0000_0020;
  localparam logic [31:0] GEOM_RST = 32'h0020_013f;
  localparam logic [31:0] BEAM_RST = 32'h0000_0004;
  localparam logic [31:0] APOD_RST = 32'h0000_ffff;
  // datapath widths and filter shifts
  localparam int SMP_W     = 16;
  localparam int PIX_W     = 6;
  localparam int SHOT_W    = 2;
  localparam int DEC_W     = 4;
  localparam int MAG_W     = 17;
  localparam int DC_SHIFT  = 4;
  localparam int LPF_SHIFT = 2;
  localparam int MIX_SHIFT = 7;
  localparam int CNT_W     = 6;
  localparam logic [5:0] CFG_BITS = 6'h38;
  localparam logic [7:0] TXDIV_MIN = 8'h02;
  localparam logic DMA_BMODE = 1'b0;
  localparam logic DMA_MD    = 1'b1;
  // shot sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_FIRE} usep_state_e;
endpackage

// ===== sim/test_ultrasound_echo_processing_chain.sv
// test_ultrasound_echo_processing_chain: self-checking bench of the chain
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_ultrasound_echo_processing_chain;
  import usep_pkg::*;
  typedef struct packed {logic [2:0] mode; logic [2:0] opt; logic dma;}
    usep_row_s;
  logic        clk, reset, psel, penable, pwrite, lclk, go, fifo_full;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, smp_valid, smp_ready, bf_clk_en;
  logic        shot_trig, cfg_sclk, cfg_sdata, cfg_load, out_valid, out_dma;
  logic [15:0] smp_data, out_data;
  logic [55:0] cfg_word;
  int          cfg_bits, err_count, num_checks, trig_cnt, ovf_bad, n;
  usep_row_s   rows [8] = '{'{MODE_B, 3'h0, DMA_BMODE},
    '{MODE_M, 3'h0, DMA_MD}, '{MODE_D, 3'h0, DMA_MD},
    '{MODE_COMPOUND, 3'h0, DMA_BMODE}, '{MODE_VOLCON, 3'h0, DMA_BMODE},
    '{MODE_B, 3'h1, DMA_BMODE}, '{MODE_B, 3'h2, DMA_BMODE},
    '{MODE_M, 3'h4, DMA_MD}};
  logic [2:0]  idle_m [2] = '{MODE_EXTVID, MODE_ARCHIVE};
  logic [7:0]  rst_a [6] = '{A_CTRL, A_SHOT, A_RXF, A_GEOM, A_BEAM, A_APOD};
  logic [31:0] rst_v [6] = '{CTRL_RST, SHOT_RST, RXF_RST, GEOM_RST,
    BEAM_RST, APOD_RST};

  usep_chain dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lclk(lclk), .smp_valid(smp_valid),
    .smp_data(smp_data), .smp_ready(smp_ready), .bf_clk_en(bf_clk_en),
    .shot_trig(shot_trig), .cfg_sclk(cfg_sclk), .cfg_sdata(cfg_sdata),
    .cfg_load(cfg_load), .fifo_full(fifo_full), .out_valid(out_valid),
    .out_data(out_data), .out_dma(out_dma));
  usep_bf_model bf (.clk(clk), .lclk(lclk), .reset(reset), .go(go),
    .smp_ready(smp_ready), .smp_valid(smp_valid), .smp_data(smp_data),
    .cfg_sclk(cfg_sclk), .cfg_sdata(cfg_sdata), .cfg_load(cfg_load),
    .cfg_word(cfg_word), .cfg_bits(cfg_bits));

  // main clock and an unrelated link clock
  always #50 clk = ~clk;
  initial
  begin
    lclk = 1'b0;
    #17;
    forever #40 lclk = ~lclk;
  end

  // count triggers and words written into a full fifo
  always @(posedge clk)
  begin
    trig_cnt <= trig_cnt + int'(shot_trig);
    ovf_bad  <= ovf_bad + int'(out_valid & fifo_full);
  end

  // one apb transfer; read data and error land in rd and er
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait for load (0), output word (1) or trigger (2), bounded
  task wait_hi(input int sel, input int lim);
    int k;
    for (k = 0; k < lim; k++)
    begin
      @(posedge clk);
      if ((sel == 0 && cfg_load === 1'b1) || (sel == 1 && out_valid === 1'b1)
        || (sel == 2 && shot_trig === 1'b1)) break;
    end
    if (k == lim)
    begin
      err_count++;
      $display("unexpected at %0t: wait %0d timed out", $time, sel);
    end
  endtask

  // verdict and end of run
  task finish_test;
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    #4000000;
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end

  // main sequence
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite, go, fifo_full} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    apb(1'b1, A_GEOM, 32'h0000_0101);
    apb(1'b1, A_SHOT, 32'h0000_0009);
    apb(1'b1, A_BEAM, 32'h5a3c_1e01);
    apb(1'b1, A_APOD, 32'h0000_7e81);
    apb(1'b0, A_BEAM, 32'h0);
    `CHK(rd, 32'h5a3c_1e02)
    // every processing mode picks its dma channel
    foreach (rows[i])
    begin
      apb(1'b1, A_CTRL, {25'h0, rows[i].opt, 1'b1, rows[i].mode});
      go <= 1'b1;
      wait_hi(1, 2000);
      `CHK(out_dma, rows[i].dma)
      if (rows[i].mode != MODE_D)
        `CHK(out_data[15:8], 8'h00)
      go <= 1'b0;
      apb(1'b1, A_CTRL, 32'h0);
      repeat (60) @(posedge clk);
    end
    // config word, clock enable and trigger period
    apb(1'b1, A_CTRL, {28'h0, 1'b1, MODE_B});
    wait_hi(0, 500);
    @(posedge clk);
    `CHK(cfg_bits, 56)
    `CHK(cfg_word, {32'h5a3c_1e02, 16'h7e81, 6'h00, 2'h1})
    wait_hi(2, 300);
    for (n = 1; n < 300; n++)
    begin
      @(posedge clk);
      if (shot_trig === 1'b1) break;
    end
    `CHK(n, 10)
    `CHK(bf_clk_en, 1'b1)
    // idle modes fire nothing and take no samples
    foreach (idle_m[i])
    begin
      apb(1'b1, A_CTRL, {28'h0, 1'b1, idle_m[i]});
      repeat (2) @(posedge clk);
      n = trig_cnt;
      go <= 1'b1;
      repeat (80) @(posedge clk);
      `CHK(trig_cnt - n, 0)
      `CHK(smp_ready, 1'b0)
      `CHK(bf_clk_en, 1'b0)
      apb(1'b0, A_STAT, 32'h0);
      `CHK(rd[1:0], 2'h0)
    end
    go <= 1'b0;
    // full fifo: words dropped, overflow flagged, then cleared
    fifo_full <= 1'b1;
    apb(1'b1, A_CTRL, {28'h0, 1'b1, MODE_B});
    go <= 1'b1;
    repeat (300) @(posedge clk);
    apb(1'b0, A_STAT, 32'h0);
    `CHK(rd[S_OVF], 1'b1)
    `CHK(ovf_bad, 0)
    go <= 1'b0;
    apb(1'b1, A_CTRL, 32'h0);
    repeat (60) @(posedge clk);
    fifo_full <= 1'b0;
    apb(1'b1, A_STAT, 32'h0000_0004);
    apb(1'b0, A_STAT, 32'h0);
    `CHK(rd[S_OVF], 1'b0)
    // unmapped address is refused
    apb(1'b0, 8'h40, 32'h0);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    // second reset, then reset values
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    foreach (rst_a[i])
    begin
      apb(1'b0, rst_a[i], 32'h0);
      `CHK(rd, rst_v[i])
    end
    finish_test();
  end
endmodule

// ===== sim/usep_bf_model.sv
// usep_bf_model: beamformer side, sample source and config receiver
`timescale 1ns/1ps
module usep_bf_model (
  // clocks and reset
  input  wire logic        clk,
  input  wire logic        lclk,
  input  wire logic        reset,
  // sample link
  input  wire logic        go,
  input  wire logic        smp_ready,
  output logic             smp_valid,
  output logic [15:0]      smp_data,
  // config serial link
  input  wire logic        cfg_sclk,
  input  wire logic        cfg_sdata,
  input  wire logic        cfg_load,
  output logic [55:0]      cfg_word,
  output int               cfg_bits
);
  logic [55:0] shift;
  logic        sclk_q;
  int          cnt;
  // receive sum steps once per channel of every subboard
  localparam int SUBS  = 16;
  localparam int CHANS = 16;

  // counting samples in pixel-major order, held until taken
  always_ff @(posedge lclk or posedge reset)
  begin
    if (reset)
    begin
      smp_valid <= 1'b0;
      smp_data  <= 16'h0000;
    end
    else if (smp_valid && smp_ready)
    begin
      smp_valid <= go;
      smp_data  <= smp_data + 16'(SUBS * CHANS);
    end
    else if (!smp_valid)
    begin
      smp_valid <= go;
      smp_data  <= ~smp_data; // unused line keeps changing
    end
  end

  // shift a bit on each rise of the config clock, latch on load
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sclk_q   <= 1'b0;
      shift    <= '0;
      cnt      <= 0;
      cfg_word <= '0;
      cfg_bits <= 0;
    end
    else
    begin
      sclk_q <= cfg_sclk;
      if (cfg_sclk && !sclk_q)
      begin
        shift <= {shift[54:0], cfg_sdata};
        cnt   <= cnt + 1;
      end
      else if (!cfg_sclk && !sclk_q)
        cnt <= 0; // a clock stopped for two cycles ends a cut frame
      if (cfg_load)
      begin
        cfg_word <= shift;
        cfg_bits <= cnt;
        cnt      <= 0;
      end
    end
  end
endmodule
